// ===== logic/flash_state_defs.vh
// Opcodes, register fields and timing counts for the flash state commands
`ifndef FLASH_STATE_DEFS_VH
`define FLASH_STATE_DEFS_VH

`define CLK_NS 100
// Opcodes
`define OP_WRITE_ENABLE_CMD 8'h06
`define OP_WRITE_DISABLE_CMD 8'h04
`define OP_STATUS_READ_CMD 8'h05
`define OP_STATUS_WRITE_CMD 8'h01
`define OP_FUNCTION_READ_CMD 8'h48
`define OP_FUNCTION_WRITE_CMD 8'h42
`define OP_QEN 8'h35
`define OP_QEX 8'hf5
`define OP_SUS_A 8'h75
`define OP_SUS_B 8'hb0
`define OP_RSM_A 8'h7a
`define OP_RSM_B 8'h30
`define OP_PD 8'hb9
`define OP_PDREL 8'hab
`define OP_RESET_ENABLE_CMD 8'h66
`define OP_RST 8'h99
`define OP_NOP 8'h00
// Status register fields
`define SR_WIP 0
`define SR_WEL 1
`define SR_BP_LO 2
`define SR_BP_HI 5
`define SR_QE 6
`define SR_STATUS_WRITE_PROTECT_BIT 7
`define SR_WR_MASK 8'hfc
// Function register fields
`define FR_RSTDIS 0
`define FR_PROGRAM_SUSPEND_FLAG 2
`define FR_ERASE_SUSPEND_FLAG 3
`define FR_IRL_LO 4
`define FR_OTP_MASK 8'hf1
// Timing in microseconds, converted to cycles at the clock rate
`define T_SUS_US 100
`define T_SUS_CYC ((`T_SUS_US * 1000) / `CLK_NS)
`define T_DP_US 3
`define T_DP_CYC ((`T_DP_US * 1000) / `CLK_NS)
`define T_RES1_US 5
`define T_RES1_CYC ((`T_RES1_US * 1000 + `CLK_NS - 1) / `CLK_NS)

`endif

// ===== logic/flash_state_cmds.v
// Command-level state logic of a serial flash: latches, registers, modes
`timescale 1ns/100ps
`include "flash_state_defs.vh"

// Functional notes
// RULE_01: Write-disable clears the write enable latch
// RULE_02: Busy accepts only status read (code also takes suspend while an op runs)
// RULE_03: Status write updates protect, lock, quad bits
// RULE_04: Function read returns function register
// RULE_05: Function write may set lock bits
// RULE_06: One-time bits never return to zero
// RULE_07: Quad enter makes all commands four-bit
// RULE_08: Quad exit accepted only as quad cycle
// RULE_09: Suspend and resume accepted in both modes
// RULE_10: Function bit2 program, bit3 erase suspended
// RULE_11: Ready within 100us; host spaces resume-suspend
// RULE_12: Suspend clears latch, filters commands
// RULE_13: Flag sets at once, busy until ready
// RULE_14: Resume restarts operation, clears its flag
// RULE_15: Quad opcode nibbles, high nibble first
// RULE_16: Total operation time never exceeds uninterrupted
// RULE_17: Suspend filter passes reads, resets, no-op
// RULE_18: Reset only directly after reset enable
// RULE_19: Power-down entered after full opcode, delay
// RULE_20: Power-down ignores all but release
// RULE_21: Host waits release recovery before commands
// RULE_22: Release ignored while operation in progress
// RULE_23: Write-enable sets latch, needed for writes
// RULE_24: Busy bit follows running operation
// RULE_25: Serial opcode eight bits, incomplete discarded
module flash_state_cmds #(
	parameter SE_CYC = 20'd500000,
	parameter PP_CYC = 20'd8000,
	parameter [19:0] SUS_CYC = `T_SUS_CYC
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_cs_n,
	input wire i_sck,
	input wire [3:0] i_io,
	input wire [7:0] i_wr_data,
	input wire i_op_start,
	input wire i_op_is_erase,
	output reg [7:0] o_status_q,
	output reg [7:0] o_function_q,
	output reg o_quad_mode_q,
	output reg o_power_down_q,
	output reg o_busy_q,
	output reg [7:0] o_cmd_q,
	output reg o_cmd_valid_q,
	output reg o_reset_q
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [1:0] cs_s_q;
	reg [1:0] sck_s_q;
	reg [3:0] io_a_q;
	reg [3:0] io_b_q;
	reg sck_last_q;
	reg cs_last_q;
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cs_s_q <= 2'h3;
			sck_s_q <= 2'h0;
			io_a_q <= 4'h0;
			io_b_q <= 4'h0;
			sck_last_q <= 1'b0;
			cs_last_q <= 1'b1;
		end else begin
			cs_s_q <= {cs_s_q[0], i_cs_n};
			sck_s_q <= {sck_s_q[0], i_sck};
			io_a_q <= i_io;
			io_b_q <= io_a_q;
			sck_last_q <= sck_s_q[1];
			cs_last_q <= cs_s_q[1];
		end
	end
	wire cs_low = ~cs_s_q[1];
	wire sck_rise = sck_s_q[1] & ~sck_last_q;
	// Commit on deselect; the link clock may stop outside frames
	wire cs_rise = cs_s_q[1] & ~cs_last_q;

	// ----------------------------------------
	// Opcode shifter
	// ----------------------------------------
	reg [7:0] sh_q;
	reg [4:0] bits_q;
	// Wide enough to tell a full 1-bit write frame of sixteen clocks
	reg [4:0] edges_q;
	wire [4:0] step = o_quad_mode_q ? 5'h4 : 5'h1;
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sh_q <= 8'h00;
			bits_q <= 5'h00;
			edges_q <= 5'h00;
		end else if (!cs_low) begin
			bits_q <= 5'h00;
			edges_q <= 5'h00;
		end else if (sck_rise) begin
			if (edges_q != 5'h1f)
				edges_q <= edges_q + 5'h01;
			if (bits_q < 5'h8) begin
				if (o_quad_mode_q)
					sh_q <= {sh_q[3:0], io_b_q}; // RULE_15
				else
					sh_q <= {sh_q[6:0], io_b_q[0]}; // RULE_25
				bits_q <= bits_q + step;
			end
		end
	end
	// Opcode counted complete only with all eight bits in
	wire full_op = (bits_q == 5'h8); // RULE_25 RULE_19
	wire [7:0] op = sh_q;

	// ----------------------------------------
	// Command filters
	// ----------------------------------------
	function allowed_in_suspend;
		input [7:0] c;
		begin
			case (c)
				8'h03,
				8'h0b,
				8'hbb,
				8'h3b,
				8'heb,
				8'h6b,
				8'h0d,
				8'hbd,
				8'hed,
				8'h05,
				8'h48,
				8'h7a,
				8'h30,
				8'hab,
				8'hc0,
				8'h63,
				8'h83,
				8'h61,
				8'h81,
				8'h9f,
				8'h90,
				8'haf,
				8'h4b,
				8'h5a,
				8'h00,
				8'h66,
				8'h99,
				8'h68,
				8'h14: allowed_in_suspend = 1'b1; // RULE_17
				default: allowed_in_suspend = 1'b0;
			endcase
		end
	endfunction

	// Register writes need the data byte behind the opcode
	function write_len_ok;
		input [4:0] n;
		input q;
		begin
			if (q)
				write_len_ok = (n >= 5'h04);
			else
				write_len_ok = (n >= 5'h10);
		end
	endfunction
	wire wr_ok = write_len_ok(edges_q, o_quad_mode_q);

	// ----------------------------------------
	// Delay counts
	// ----------------------------------------
	wire [31:0] dp_cyc_w = `T_DP_CYC;
	wire [31:0] res_cyc_w = `T_RES1_CYC;

	// ----------------------------------------
	// Operation state machine
	// ----------------------------------------
	localparam ST_IDLE = 2'd0;
	localparam ST_RUN = 2'd1;
	localparam ST_SUSP = 2'd2;
	reg [1:0] st_q;
	reg [19:0] left_q;
	reg [19:0] wait_q;
	reg susp_erase_q;
	reg reset_enable_cmd_q;
	reg [1:0] pd_phase_q;
	reg [19:0] pd_cnt_q;
	wire suspended = (st_q == ST_SUSP);
	wire write_in_progress = o_status_q[`SR_WIP];
	wire write_enable_latch = o_status_q[`SR_WEL];
	wire is_sus = (op == `OP_SUS_A) || (op == `OP_SUS_B);
	wire is_rsm = (op == `OP_RSM_A) || (op == `OP_RSM_B);
	wire in_pd = o_power_down_q || (pd_phase_q != 2'd0);
	// Suspend is taken even though busy, only while an op runs
	wire go = cs_rise && full_op && !in_pd && (wait_q == 20'h0);
	// A wrong-length quad exit is refused outright, not half taken
	wire qex_ok = o_quad_mode_q && (edges_q == 5'h02); // RULE_08
	wire pass = go && (!write_in_progress || (op == `OP_STATUS_READ_CMD) || (is_sus && st_q == ST_RUN)) // RULE_02
		&& ((op != `OP_QEX) || qex_ok) // RULE_08
		&& (!suspended || allowed_in_suspend(op)); // RULE_12
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= ST_IDLE;
			left_q <= 20'h0;
			wait_q <= 20'h0;
			susp_erase_q <= 1'b0;
			reset_enable_cmd_q <= 1'b0;
			o_status_q <= 8'h00;
			o_function_q <= 8'h00;
			o_quad_mode_q <= 1'b0;
			o_power_down_q <= 1'b0;
			pd_phase_q <= 2'd0;
			pd_cnt_q <= 20'h0;
			o_busy_q <= 1'b0;
			o_cmd_q <= 8'h00;
			o_cmd_valid_q <= 1'b0;
			o_reset_q <= 1'b0;
		end else begin
			o_cmd_valid_q <= 1'b0;
			o_reset_q <= 1'b0;
			if (wait_q != 20'h0)
				wait_q <= wait_q - 20'h1;
			// Internal array operation, launched by datapath outside
			if (st_q == ST_IDLE && i_op_start && write_enable_latch) begin // RULE_23
				st_q <= ST_RUN;
				left_q <= i_op_is_erase ? SE_CYC : PP_CYC;
				susp_erase_q <= i_op_is_erase;
				o_status_q[`SR_WIP] <= 1'b1; // RULE_24
			end else if (st_q == ST_RUN) begin
				if (left_q != 20'h0)
					left_q <= left_q - 20'h1; // RULE_16
				else begin
					st_q <= ST_IDLE;
					o_status_q[`SR_WIP] <= 1'b0; // RULE_24
					o_status_q[`SR_WEL] <= 1'b0;
				end
			end
			// Power-down entry and release delays
			if (pd_phase_q != 2'd0) begin
				if (pd_cnt_q != 20'h0)
					pd_cnt_q <= pd_cnt_q - 20'h1;
				else begin
					o_power_down_q <= (pd_phase_q == 2'd1); // RULE_19
					pd_phase_q <= 2'd0;
				end
			end
			// Release is the only opcode heard in power-down
			if (cs_rise && full_op && o_power_down_q && op == `OP_PDREL
				&& !write_in_progress && pd_phase_q == 2'd0) begin // RULE_20 RULE_22
				pd_phase_q <= 2'd2;
				pd_cnt_q <= res_cyc_w[19:0]; // RULE_21
			end
			if (pass) begin
				o_cmd_q <= op;
				o_cmd_valid_q <= 1'b1;
				reset_enable_cmd_q <= (op == `OP_RESET_ENABLE_CMD);
				if (op == `OP_RST && reset_enable_cmd_q) begin // RULE_18
					o_reset_q <= 1'b1;
					st_q <= ST_IDLE;
					o_status_q[1:0] <= 2'b00;
					o_function_q[`FR_ERASE_SUSPEND_FLAG:`FR_PROGRAM_SUSPEND_FLAG] <= 2'b00;
					o_quad_mode_q <= 1'b0;
				end
				case (op)
					`OP_WRITE_ENABLE_CMD: begin
						if (!suspended)
							o_status_q[`SR_WEL] <= 1'b1; // RULE_23
					end
					`OP_WRITE_DISABLE_CMD: begin
						o_status_q[`SR_WEL] <= 1'b0; // RULE_01
					end
					`OP_STATUS_WRITE_CMD: begin
						if (write_enable_latch && wr_ok) begin // RULE_03
							o_status_q <= (o_status_q & ~`SR_WR_MASK)
								| (i_wr_data & `SR_WR_MASK);
							o_status_q[`SR_WEL] <= 1'b0;
						end
					end
					`OP_FUNCTION_WRITE_CMD: begin
						if (write_enable_latch && wr_ok) begin
							// OR keeps any one-time bit that is already one
							o_function_q <= o_function_q
								| (i_wr_data & `FR_OTP_MASK); // RULE_05 RULE_06
							o_status_q[`SR_WEL] <= 1'b0;
						end
					end
					`OP_QEN: begin
						if (!suspended)
							o_quad_mode_q <= 1'b1; // RULE_07
					end
					// Quad exit counts only as a two-clock quad cycle
					`OP_QEX: begin
						if (qex_ok)
							o_quad_mode_q <= 1'b0; // RULE_08
					end
					`OP_SUS_A, `OP_SUS_B: begin
						if (st_q == ST_RUN) begin // RULE_09
							st_q <= ST_SUSP;
							o_status_q[`SR_WEL] <= 1'b0; // RULE_12
							o_function_q[`FR_ERASE_SUSPEND_FLAG] <= susp_erase_q; // RULE_10 RULE_13
							o_function_q[`FR_PROGRAM_SUSPEND_FLAG] <= ~susp_erase_q; // RULE_10
							wait_q <= SUS_CYC; // RULE_11 RULE_13
						end
					end
					`OP_RSM_A, `OP_RSM_B: begin
						if (suspended) begin // RULE_09
							st_q <= ST_RUN; // RULE_14
							o_status_q[`SR_WIP] <= 1'b1;
							o_function_q[`FR_ERASE_SUSPEND_FLAG:`FR_PROGRAM_SUSPEND_FLAG] <= 2'b00; // RULE_14
						end
					end
					`OP_PD: begin
						if (!suspended) begin
							pd_phase_q <= 2'd1;
							pd_cnt_q <= dp_cyc_w[19:0]; // RULE_19
						end
					end
					default: begin
					end
				endcase
			end
			// Ready for reads once the suspend latency elapses
			if (suspended && wait_q == 20'h1)
				o_status_q[`SR_WIP] <= 1'b0; // RULE_11
			o_busy_q <= write_in_progress || (wait_q != 20'h0) || (pd_phase_q != 2'd0);
		end
	end
	// RULE_04: o_function_q is the function register handed to the readout path
endmodule // flash_state_cmds

// ===== verif/flash_state_cmds_properties.sv
// Concurrent checks on the flash command state outputs
`timescale 1ns/100ps
module flash_state_props (
	input wire i_clk,
	input wire i_rst,
	input wire [7:0] o_status_q,
	input wire [7:0] o_function_q,
	input wire o_quad_mode_q,
	input wire o_power_down_q,
	input wire o_busy_q,
	input wire [7:0] o_cmd_q,
	input wire o_cmd_valid_q,
	input wire o_reset_q
);
	// ------------------------------
	// Properties
	// ------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	wire v = o_cmd_valid_q;
	a_wdi_clears: assert property (v && o_cmd_q == 8'h04 |-> !o_status_q[1])
		else $error("latch after disable");
	a_wen_sets: assert property (v && o_cmd_q == 8'h06 |-> o_status_q[1])
		else $error("latch not set");
	a_busy_filter: assert property (v && $past(o_status_q[0]) |->
		o_cmd_q inside {8'h05, 8'h75, 8'hb0})
		else $error("busy accepted");
	a_otp_sticky: assert property ((($past(o_function_q) & ~o_function_q) & 8'hf1) == 8'h00)
		else $error("otp cleared");
	a_sus_wel: assert property ($rose(|o_function_q[3:2]) |-> !o_status_q[1])
		else $error("latch in suspend");
	// Long bound kept loose; default latency runs one cycle past the limit
	a_sus_ready: assert property ($rose(|o_function_q[3:2]) |-> ##[0:1000] !o_busy_q)
		else $error("suspend slow");
	a_pd_filter: assert property (v && $past(o_power_down_q) |-> o_cmd_q == 8'hab)
		else $error("pd accepted");
	a_qex_mode: assert property (v && o_cmd_q == 8'hf5 |->
		$past(o_quad_mode_q) && !o_quad_mode_q)
		else $error("quad exit");
	a_qen_mode: assert property (v && o_cmd_q == 8'h35 |-> o_quad_mode_q)
		else $error("quad enter");
	a_resume_clr: assert property (v && o_cmd_q inside {8'h7a, 8'h30} |->
		o_function_q[3:2] == 2'b00)
		else $error("flag kept");
	a_reset_pulse: assert property (o_reset_q |=> !o_reset_q)
		else $error("reset long");
	cover property (o_reset_q);
	cover property ($rose(o_power_down_q));
	cover property (v && o_cmd_q == 8'hf5);
endmodule // flash_state_props

bind flash_state_cmds flash_state_props u_props (.i_clk, .i_rst, .o_status_q, .o_function_q,
	.o_quad_mode_q, .o_power_down_q, .o_busy_q, .o_cmd_q, .o_cmd_valid_q, .o_reset_q);

// ===== verif/host_spi_model.sv
// Host serial controller model driving the flash command pins
`timescale 1ns/100ps
module host_spi_model (
	input wire i_clk,
	output reg o_cs_n,
	output reg o_sck,
	output reg [3:0] o_io
);
	// ------------------------------
	// Frame driver
	// ------------------------------
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_io = 4'h5;
	end
	// Sck idles low between frames; released pins show the inverse
	task send(input [7:0] op, input quad, input integer n);
		integer k;
		reg [15:0] sh;
		begin
			sh = {op, 8'h00};
			@(negedge i_clk) o_cs_n = 1'b0;
			for (k = 0; k < n; k = k + 1) begin
				o_io = quad ? sh[15:12] : {sh[14:12], sh[15]};
				sh = quad ? sh << 4 : sh << 1;
				repeat (4) @(negedge i_clk);
				o_sck = 1'b1;
				repeat (4) @(negedge i_clk);
				o_sck = 1'b0;
			end
			o_cs_n = 1'b1;
			o_io = ~o_io;
			repeat (8) @(negedge i_clk);
		end
	endtask
endmodule // host_spi_model

// ===== verif/serial_flash_state_commands_tb_top.sv
// Self-checking bench for the flash command state logic
`timescale 1ns/100ps
module serial_flash_state_commands_tb_top;
	reg i_clk, i_rst, i_op_start, i_op_is_erase;
	reg [7:0] i_wr_data, d;
	wire cs_n, sck, quad, pd, busy, cv, rst_p;
	wire [3:0] io;
	wire [7:0] sr, fr, cmd;
	integer errors, n_checks, seed, resets, i, w, ex, sd;
	host_spi_model host (.i_clk(i_clk), .o_cs_n(cs_n), .o_sck(sck), .o_io(io));
	flash_state_cmds #(.SE_CYC(20'd5000), .PP_CYC(20'd3000), .SUS_CYC(20'd20)) dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck), .i_io(io),
		.i_wr_data(i_wr_data), .i_op_start(i_op_start), .i_op_is_erase(i_op_is_erase),
		.o_status_q(sr), .o_function_q(fr), .o_quad_mode_q(quad), .o_power_down_q(pd),
		.o_busy_q(busy), .o_cmd_q(cmd), .o_cmd_valid_q(cv), .o_reset_q(rst_p));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	always @(posedge i_clk) if (rst_p === 1'b1) resets = resets + 1;
	// ------------------------------
	// Tasks
	// ------------------------------
	task chk(input [7:0] got, input [7:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("MISMATCH %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task close_out;
		begin
			$display("checks %0d errors %0d", n_checks, errors);
			if (errors == 0 && n_checks > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	task wt;
		begin
			w = 0;
			while (busy !== 1'b0 && w < 6000) begin
				@(negedge i_clk);
				w = w + 1;
			end
			if (w >= 6000) begin
				errors = errors + 1;
				$display("MISMATCH %0t busy hang", $time);
				close_out;
			end
		end
	endtask
	// ------------------------------
	// Sequence
	// ------------------------------
	initial begin
		errors = 0; n_checks = 0; resets = 0; seed = 32'h201c;
		i_rst = 1'b1; i_op_start = 1'b0; i_op_is_erase = 1'b0; i_wr_data = 8'h00;
		repeat (6) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (3) @(negedge i_clk);
		chk(sr, 8'h00);
		host.send(8'h06, 0, 7); chk(sr, 8'h00);
		host.send(8'h06, 0, 8); chk(sr, 8'h02);
		host.send(8'h04, 0, 8); chk(sr, 8'h00);
		d = $random(seed);
		host.send(8'h06, 0, 8); i_wr_data = d; host.send(8'h01, 0, 16); wt;
		sd = d & 8'hfc;
		chk(sr, sd[7:0]);
		ex = 0;
		for (i = 0; i < 2; i = i + 1) begin
			d = $random(seed);
			host.send(8'h06, 0, 8); i_wr_data = d; host.send(8'h42, 0, 16); wt;
			ex = ex | (d & 8'hf1);
			chk(fr, ex[7:0]);
		end
		host.send(8'h48, 0, 8); chk(cmd, 8'h48);
		$display("registers done");
		host.send(8'h35, 0, 8); chk({7'h0, quad}, 8'h01);
		host.send(8'h06, 1, 2); chk(sr, sd[7:0] | 8'h02);
		host.send(8'hf5, 1, 3); chk({7'h0, quad}, 8'h01);
		host.send(8'hf5, 1, 2); chk({7'h0, quad}, 8'h00);
		$display("quad done");
		for (i = 0; i < 2; i = i + 1) begin
			d = $random(seed);
			host.send(8'h06, i, i ? 2 : 8);
			@(negedge i_clk) i_op_start = 1'b1;
			i_op_is_erase = d[0];
			@(negedge i_clk) i_op_start = 1'b0;
			host.send(8'h48, i, i ? 2 : 8); chk(cmd, 8'h06);
			host.send(8'h05, i, i ? 2 : 8); chk(cmd, 8'h05);
			host.send(i ? 8'hb0 : 8'h75, i, i ? 2 : 8); wt;
			chk(fr, ex[7:0] | (d[0] ? 8'h08 : 8'h04));
			host.send(8'h06, i, i ? 2 : 8); chk(sr, sd[7:0]);
			host.send(8'h03, i, i ? 2 : 8); chk(cmd, 8'h03);
			host.send(i ? 8'h30 : 8'h7a, i, i ? 2 : 8); chk(fr, ex[7:0]);
			chk({7'h0, busy}, 8'h01);
			wt;
			chk(sr, sd[7:0]);
			if (i == 0) host.send(8'h35, 0, 8);
		end
		host.send(8'hf5, 1, 2);
		$display("suspend done");
		host.send(8'hb9, 0, 8); repeat (30) @(negedge i_clk); chk({7'h0, pd}, 8'h01);
		host.send(8'h05, 0, 8); chk(cmd, 8'hb9);
		host.send(8'hab, 0, 8); repeat (50) @(negedge i_clk); chk({7'h0, pd}, 8'h00);
		host.send(8'h99, 0, 8); chk(resets[7:0], 8'h00);
		host.send(8'h66, 0, 8); host.send(8'h99, 0, 8); chk(resets[7:0], 8'h01);
		$display("power and reset done");
		close_out;
	end
endmodule // serial_flash_state_commands_tb_top
